// *** rtl/host_cmd_ctrl.sv ***
// Host end: Wishbone-controlled access engine for the device registers
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
module host_cmd_ctrl
    import cmd_reg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    cmd_link_if.host         link
);
    typedef enum logic [1:0] {IDLE, XFER} state_t;

    state_t      state_r;
    logic        wb_ack_r;
    logic [31:0] wb_dat_r;
    logic        we_r;
    logic [7:0]  ofs_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic        busy_r;
    logic        refused_r;
    logic        pend_r;
    logic        is_tickle_r;
    logic        req_r;
    logic [7:0]  l_addr_r;
    logic [31:0] l_wdata_r;
    logic        l_we_r;
    logic [31:0] intv_r;
    logic [31:0] wdt_cnt_r;
    logic        tickle_due_r;

    wire        wb_take  = wb_cyc_i && wb_stb_i && !wb_ack_r;
    wire        wb_wr    = wb_take && wb_we_i;
    wire        w_ctrl   = wb_wr && wb_adr_i == HOFS_CTRL && wb_sel_i[0];
    wire        start    = w_ctrl && wb_dat_i[HCTRL_START] && !busy_r;
    wire [7:0]  new_ofs  = wb_dat_i[HCTRL_OFS_LSB +: 8];
    // Only offsets of the device map are legal targets
    wire        ofs_ok   = new_ofs == OFS_DEVICE_COMMAND ||
                           (new_ofs >= OFS_DEBUG_CONTROL_ONE &&
                            new_ofs <= OFS_STORAGE_PROTECTION && !new_ofs[0]);
    wire        is_cmd   = ofs_r == OFS_DEVICE_COMMAND;
    // Keys are inserted whenever the matching command bit is set
    wire [7:0]  skey     = (is_cmd && wdata_r[BIT_NVM_STORE]) ? NVM_STORE_KEY :
                           wdata_r[STORE_KEY_MSB:STORE_KEY_LSB];
    wire [7:0]  tkey     = (is_cmd && wdata_r[BIT_SELFTEST]) ? SELFTEST_KEY :
                           wdata_r[SELFTEST_KEY_MSB:SELFTEST_KEY_LSB];
    wire [31:0] sw_word  = is_cmd ? {wdata_r[31:28], skey, wdata_r[19:9], tkey,
                                     1'b0} : wdata_r;
    wire [31:0] tkl_word = 32'h0000_0001 << BIT_WDT_TICKLE;
    wire [31:0] status_v = {30'h0000_0000, refused_r, busy_r};
    wire [31:0] rd_mux   =
        (wb_adr_i == HOFS_CTRL)     ? {16'h0000, ofs_r, 6'h00, we_r, 1'b0} :
        (wb_adr_i == HOFS_WDATA)    ? wdata_r :
        (wb_adr_i == HOFS_RDATA)    ? rdata_r :
        (wb_adr_i == HOFS_STATUS)   ? status_v :
        (wb_adr_i == HOFS_WDT_INTV) ? intv_r : 32'h0000_0000;

    // Wishbone slave: ack one cycle after strobe, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack_r <= wb_take;
            if (wb_take && !wb_we_i) begin
                wb_dat_r <= rd_mux;
            end
        end
    end

    // Software-written setup registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdata_r <= 32'h0000_0000;
            intv_r  <= 32'h0000_0000;
        end else begin
            if (wb_wr && wb_adr_i == HOFS_WDATA) begin
                for (int i = 0; i < 4; i++) begin
                    if (wb_sel_i[i]) begin
                        wdata_r[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                    end
                end
            end
            if (wb_wr && wb_adr_i == HOFS_WDT_INTV) begin
                for (int i = 0; i < 4; i++) begin
                    if (wb_sel_i[i]) begin
                        intv_r[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                    end
                end
            end
        end
    end

    // Watchdog interval timer; zero interval disables tickling
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_cnt_r    <= 32'h0000_0000;
            tickle_due_r <= 1'b0;
        end else if (intv_r == 32'h0000_0000) begin
            wdt_cnt_r    <= 32'h0000_0000;
            tickle_due_r <= 1'b0;
        end else if (wdt_cnt_r >= intv_r - 32'h0000_0001) begin
            wdt_cnt_r    <= 32'h0000_0000;
            tickle_due_r <= 1'b1;
        end else begin
            wdt_cnt_r <= wdt_cnt_r + 32'h0000_0001;
            // Consumed at launch; a pending command must not keep it set
            if (state_r == IDLE) begin
                tickle_due_r <= 1'b0;
            end
        end
    end

    // Accept software command; refused offsets never reach the link
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            we_r      <= 1'b0;
            ofs_r     <= 8'h00;
            pend_r    <= 1'b0;
            refused_r <= 1'b0;
        end else if (start) begin
            we_r      <= wb_dat_i[HCTRL_WRITE];
            ofs_r     <= new_ofs;
            pend_r    <= ofs_ok;
            refused_r <= !ofs_ok;
        end else if (state_r == IDLE && pend_r && !tickle_due_r) begin
            pend_r <= 1'b0;
        end
    end

    // Link sequencer: tickle has priority over a pending command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r     <= IDLE;
            req_r       <= 1'b0;
            l_we_r      <= 1'b0;
            l_addr_r    <= 8'h00;
            l_wdata_r   <= 32'h0000_0000;
            is_tickle_r <= 1'b0;
            rdata_r     <= 32'h0000_0000;
        end else begin
            case (state_r)
                IDLE: begin
                    if (tickle_due_r) begin
                        req_r       <= 1'b1;
                        l_we_r      <= 1'b1;
                        l_addr_r    <= OFS_DEVICE_COMMAND;
                        l_wdata_r   <= tkl_word;
                        is_tickle_r <= 1'b1;
                        state_r     <= XFER;
                    end else if (pend_r) begin
                        req_r       <= 1'b1;
                        l_we_r      <= we_r;
                        l_addr_r    <= ofs_r;
                        l_wdata_r   <= sw_word;
                        is_tickle_r <= 1'b0;
                        state_r     <= XFER;
                    end
                end
                XFER: begin
                    if (link.ack) begin
                        req_r   <= 1'b0;
                        state_r <= IDLE;
                        if (!l_we_r && !is_tickle_r) begin
                            rdata_r <= link.rdata;
                        end
                    end
                end
                default: state_r <= IDLE;
            endcase
        end
    end

    // Busy from start until the software access completes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
        end else if (start && ofs_ok) begin
            busy_r <= 1'b1;
        end else if (state_r == XFER && link.ack && !is_tickle_r) begin
            busy_r <= 1'b0;
        end
    end

    assign wb_ack_o   = wb_ack_r;
    assign wb_dat_o   = wb_dat_r;
    assign link.req   = req_r;
    assign link.we    = l_we_r;
    assign link.addr  = l_addr_r;
    assign link.wdata = l_wdata_r;
endmodule // host_cmd_ctrl

// *** rtl/cmd_reg_pkg.sv ***
// Shared constants for the device command register link and both ends
package cmd_reg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Device register offsets
    localparam logic [7:0] OFS_DEVICE_COMMAND     = 8'hEA;
    localparam logic [7:0] OFS_DEBUG_CONTROL_ONE  = 8'hEC;
    localparam logic [7:0] OFS_DEBUG_CONTROL_TWO  = 8'hEE;
    localparam logic [7:0] OFS_CURRENT_LOOP_GAINS = 8'hF0;
    localparam logic [7:0] OFS_SPEED_LOOP_GAINS   = 8'hF2;
    localparam logic [7:0] OFS_MONITOR_OUTPUT_ONE = 8'hF4;
    localparam logic [7:0] OFS_MONITOR_OUTPUT_TWO = 8'hF6;
    localparam logic [7:0] OFS_STORAGE_PROTECTION = 8'hF8;
    localparam logic [31:0] DEVICE_COMMAND_RESET  = 32'h0000_0000;

    // device_command field positions
    localparam int BIT_NVM_STORE     = 31;
    localparam int BIT_NVM_LOAD      = 30;
    localparam int BIT_FAULT_CLEAR   = 29;
    localparam int BIT_RETRY_CLEAR   = 28;
    localparam int STORE_KEY_MSB     = 27;
    localparam int STORE_KEY_LSB     = 20;
    localparam int ANGLE_MSB         = 19;
    localparam int ANGLE_LSB         = 11;
    localparam int BIT_WDT_TICKLE    = 10;
    localparam int BIT_SELFTEST      = 9;
    localparam int SELFTEST_KEY_MSB  = 8;
    localparam int SELFTEST_KEY_LSB  = 1;
    localparam int BIT_FORCE_ALIGN   = 14;  // In debug_control_one

    localparam logic [7:0] NVM_STORE_KEY = 8'hA5;
    localparam logic [7:0] SELFTEST_KEY  = 8'hBE;
    localparam logic [8:0] FULL_TURN_DEG = 9'h168;  // 360 degrees

    // Start-up method codes that hold the align state
    localparam logic [2:0] STARTUP_ALIGN        = 3'h1;
    localparam logic [2:0] STARTUP_DOUBLE_ALIGN = 3'h2;

    // Host controller Wishbone register byte offsets
    localparam logic [4:0] HOFS_CTRL     = 5'h00;
    localparam logic [4:0] HOFS_WDATA    = 5'h04;
    localparam logic [4:0] HOFS_RDATA    = 5'h08;
    localparam logic [4:0] HOFS_STATUS   = 5'h0C;
    localparam logic [4:0] HOFS_WDT_INTV = 5'h10;
    localparam int HCTRL_START     = 0;
    localparam int HCTRL_WRITE     = 1;
    localparam int HCTRL_OFS_LSB   = 8;
    localparam int HSTAT_BUSY      = 0;
    localparam int HSTAT_REFUSED   = 1;
endpackage

// *** rtl/cmd_link_if.sv ***
// Register access link between host controller and device
`timescale 1ns/1ps
interface cmd_link_if;
    import cmd_reg_pkg::*;
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              ack;

    modport host   (output req, output we, output addr, output wdata,
                    input rdata, input ack);
    modport device (input req, input we, input addr, input wdata,
                    output rdata, output ack);
endinterface

// *** rtl/device_command_regs.sv ***
// Device end: command register and algorithm-control register bank
`timescale 1ns/1ps
module device_command_regs
    import cmd_reg_pkg::*;
#(
    parameter bit SELFTEST_SUPPORTED = 1'b1
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    cmd_link_if.device      link,
    output logic            nvm_store_req_o,
    output logic            nvm_load_req_o,
    input  wire logic       nvm_done_i,
    output logic            fault_clear_o,
    output logic            retry_clear_o,
    output logic            wdt_tickle_o,
    output logic            selftest_start_o,
    input  wire logic       selftest_done_i,
    input  wire logic [2:0] startup_method_i,
    output logic            align_hold_o,
    output logic [8:0]      align_angle_o
);
    logic        ack_r;
    logic        store_r;
    logic        load_r;
    logic        tickle_r;
    logic        selftest_r;
    logic [7:0]  stkey_r;
    logic [8:0]  angle_r;
    logic        fclr_r;
    logic        rclr_r;
    logic        ststart_r;
    logic [8:0]  applied_r;
    logic        hold_r;
    logic [31:0] rdata_r;
    logic [31:0] dbg1_r;
    logic [31:0] dbg2_r;
    logic [31:0] cur_r;
    logic [31:0] spd_r;
    logic [31:0] mon1_r;
    logic [31:0] mon2_r;
    logic [31:0] prot_r;

    // Request taken once, in the cycle before the ack
    wire        take     = link.req && !ack_r;
    wire        wr       = take && link.we;
    wire        rd       = take && !link.we;
    wire [31:0] wd       = link.wdata;
    wire        hit_cmd  = link.addr == OFS_DEVICE_COMMAND;
    wire        wr_cmd   = wr && hit_cmd;
    wire        key_ok   = wd[STORE_KEY_MSB:STORE_KEY_LSB] == NVM_STORE_KEY;
    wire        store_go = wr_cmd && wd[BIT_NVM_STORE] && key_ok;
    wire        load_go  = wr_cmd && wd[BIT_NVM_LOAD];
    wire        st_key   = wd[SELFTEST_KEY_MSB:SELFTEST_KEY_LSB] == SELFTEST_KEY;
    wire        st_go    = SELFTEST_SUPPORTED && wr_cmd && wd[BIT_SELFTEST] && st_key;
    // A copy in flight blocks new copy orders; other fields still land
    wire        nvm_busy = store_r || load_r;

    // Reduce 0..511 modulo 360: a single subtraction covers the range
    wire [8:0]  angle_mod = (angle_r >= FULL_TURN_DEG) ?
                            angle_r - FULL_TURN_DEG : angle_r;
    wire        align_sel = (startup_method_i == STARTUP_ALIGN) ||
                            (startup_method_i == STARTUP_DOUBLE_ALIGN);

    // Read-back image; write-only fields read zero
    wire [31:0] cmd_view = {store_r, load_r, 19'h0_0000, tickle_r, selftest_r,
                            stkey_r, 1'b0};
    wire [31:0] rd_mux =
        (link.addr == OFS_DEVICE_COMMAND)     ? cmd_view :
        (link.addr == OFS_DEBUG_CONTROL_ONE)  ? dbg1_r :
        (link.addr == OFS_DEBUG_CONTROL_TWO)  ? dbg2_r :
        (link.addr == OFS_CURRENT_LOOP_GAINS) ? cur_r  :
        (link.addr == OFS_SPEED_LOOP_GAINS)   ? spd_r  :
        (link.addr == OFS_MONITOR_OUTPUT_ONE) ? mon1_r :
        (link.addr == OFS_MONITOR_OUTPUT_TWO) ? mon2_r :
        (link.addr == OFS_STORAGE_PROTECTION) ? prot_r : 32'h0000_0000;

    // Link answer: ack one cycle after the request is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= take;
            if (rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Storage copy bits: set by command, cleared on completion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            store_r <= DEVICE_COMMAND_RESET[BIT_NVM_STORE];
            load_r  <= DEVICE_COMMAND_RESET[BIT_NVM_LOAD];
        end else if (nvm_busy) begin
            if (nvm_done_i) begin
                store_r <= 1'b0;
                load_r  <= 1'b0;
            end
        // Store wins when both copy bits arrive in one write with a valid store key
        end else if (store_go) begin
            store_r <= 1'b1;
        end else if (load_go) begin
            load_r  <= 1'b1;
        end
    end

    // Command fields and one-cycle action pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            angle_r    <= 9'h000;
            stkey_r    <= 8'h00;
            tickle_r   <= 1'b0;
            selftest_r <= 1'b0;
            fclr_r     <= 1'b0;
            rclr_r     <= 1'b0;
            ststart_r  <= 1'b0;
        end else begin
            fclr_r    <= wr_cmd && wd[BIT_FAULT_CLEAR];
            rclr_r    <= wr_cmd && wd[BIT_RETRY_CLEAR];
            ststart_r <= st_go;
            // Tickle lives one cycle then drops by itself
            tickle_r  <= wr_cmd && wd[BIT_WDT_TICKLE];
            // Angle and self-test key fields: every command write replaces them
            if (wr_cmd) begin
                angle_r <= wd[ANGLE_MSB:ANGLE_LSB];
                stkey_r <= wd[SELFTEST_KEY_MSB:SELFTEST_KEY_LSB];
            end
            if (st_go) begin
                selftest_r <= 1'b1;
            end else if (selftest_done_i) begin
                selftest_r <= 1'b0;
            end
        end
    end

    // Algorithm-control words, stored as written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbg1_r <= 32'h0000_0000;
            dbg2_r <= 32'h0000_0000;
            cur_r  <= 32'h0000_0000;
            spd_r  <= 32'h0000_0000;
            mon1_r <= 32'h0000_0000;
            mon2_r <= 32'h0000_0000;
            prot_r <= 32'h0000_0000;
        end else if (wr) begin
            if (link.addr == OFS_DEBUG_CONTROL_ONE) begin
                dbg1_r <= wd;
            end else if (link.addr == OFS_DEBUG_CONTROL_TWO) begin
                dbg2_r <= wd;
            end else if (link.addr == OFS_CURRENT_LOOP_GAINS) begin
                cur_r <= wd;
            end else if (link.addr == OFS_SPEED_LOOP_GAINS) begin
                spd_r <= wd;
            end else if (link.addr == OFS_MONITOR_OUTPUT_ONE) begin
                mon1_r <= wd;
            end else if (link.addr == OFS_MONITOR_OUTPUT_TWO) begin
                mon2_r <= wd;
            end else if (link.addr == OFS_STORAGE_PROTECTION) begin
                prot_r <= wd;
            end
        end
    end

    // Forced-align state and applied angle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r    <= 1'b0;
            applied_r <= 9'h000;
        end else begin
            hold_r <= dbg1_r[BIT_FORCE_ALIGN] && align_sel;
            // Angle reaches the motor only while force align is on
            applied_r <= dbg1_r[BIT_FORCE_ALIGN] ? angle_mod : 9'h000;
        end
    end

    // Pins come straight from flip-flops
    assign link.ack         = ack_r;
    assign link.rdata       = rdata_r;
    assign nvm_store_req_o  = store_r;
    assign nvm_load_req_o   = load_r;
    assign fault_clear_o    = fclr_r;
    assign retry_clear_o    = rclr_r;
    assign wdt_tickle_o     = tickle_r;
    assign selftest_start_o = ststart_r;
    assign align_hold_o     = hold_r;
    assign align_angle_o    = applied_r;
endmodule // device_command_regs

// *** tb/cmd_link_properties.sv ***
// Checker for the command link between host controller and device end
`timescale 1ns/1ps
module cmd_link_properties
    import cmd_reg_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              req,
    input wire logic              we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              ack
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Command register reads answered and writes requested
    wire logic cmd_rd = ack && !we && (addr == OFS_DEVICE_COMMAND);
    wire logic cmd_wr = req && we && (addr == OFS_DEVICE_COMMAND);

    chk_reset_idle:
    assert property ($fell(rst_i) |-> !req && !ack) else $error("link not idle after reset");
    chk_ack_after_take:
    assert property (req && !ack |=> ack) else $error("ack late");
    chk_ack_single:
    assert property (ack |=> !ack) else $error("ack longer than one cycle");
    // An ack with no request behind it would retire a phantom transfer
    chk_ack_cause:
    assert property (ack |-> $past(req) && !$past(ack)) else $error("ack without request");
    chk_req_held:
    assert property (req && !ack |=> req && $stable(we) && $stable(addr) && $stable(wdata))
        else $error("request changed before ack");
    chk_req_release:
    assert property (ack |=> !req) else $error("request not released");
    chk_reserved_bit_zero:
    assert property (cmd_rd |-> rdata[0] == 1'b0) else $error("reserved bit read high");
    chk_tickle_self_clear:
    assert property (cmd_rd |-> !rdata[BIT_WDT_TICKLE]) else $error("tickle bit not cleared");
    chk_store_key_sent:
    assert property (cmd_wr && wdata[BIT_NVM_STORE]
        |-> wdata[STORE_KEY_MSB:STORE_KEY_LSB] == NVM_STORE_KEY) else $error("store key wrong");
    chk_test_key_sent:
    assert property (cmd_wr && wdata[BIT_SELFTEST]
        |-> wdata[SELFTEST_KEY_MSB:SELFTEST_KEY_LSB] == SELFTEST_KEY) else $error("test key wrong");
    chk_legal_offset:
    assert property (req |-> addr == OFS_DEVICE_COMMAND || (addr >= OFS_DEBUG_CONTROL_ONE &&
        addr <= OFS_STORAGE_PROTECTION && !addr[0])) else $error("reserved offset on link");
endmodule // cmd_link_properties

// *** tb/testbench.sv ***
// Testbench joining host controller and device end over the command link
`timescale 1ns/1ps
module testbench;
    import cmd_reg_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we, ack_o, done_nvm, done_st;
    logic        store_o, load_o, flt_o, rty_o, tkl_o, st_o, hold_o;
    logic [4:0]  adr;
    logic [31:0] dat, dat_o, q;
    logic [2:0]  method;
    logic [8:0]  angle_o;
    int          mismatches = 0;
    int          checks_done = 0;
    int          n_flt = 0, n_rty = 0, n_tkl = 0, n_st = 0, n_req = 0;

    cmd_link_if cmd_link_if_i ();

    host_cmd_ctrl host_cmd_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack_o), .link(cmd_link_if_i));

    device_command_regs device_command_regs_i (.clk_i(clk_i), .rst_i(rst_i),
        .link(cmd_link_if_i), .nvm_store_req_o(store_o), .nvm_load_req_o(load_o),
        .nvm_done_i(done_nvm), .fault_clear_o(flt_o), .retry_clear_o(rty_o),
        .wdt_tickle_o(tkl_o), .selftest_start_o(st_o), .selftest_done_i(done_st),
        .startup_method_i(method), .align_hold_o(hold_o), .align_angle_o(angle_o));

    cmd_link_properties cmd_link_properties_i (.clk_i(clk_i), .rst_i(rst_i),
        .req(cmd_link_if_i.req), .we(cmd_link_if_i.we), .addr(cmd_link_if_i.addr),
        .wdata(cmd_link_if_i.wdata), .rdata(cmd_link_if_i.rdata), .ack(cmd_link_if_i.ack));

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Cycles each pulse output stands high, plus completed link transfers; pulses must be exactly one cycle
    always @(posedge clk_i) begin
        n_flt <= n_flt + int'(flt_o === 1'b1);
        n_rty <= n_rty + int'(rty_o === 1'b1);
        n_tkl <= n_tkl + int'(tkl_o === 1'b1);
        n_st  <= n_st + int'(st_o === 1'b1);
        n_req <= n_req + int'(cmd_link_if_i.req === 1'b1 && cmd_link_if_i.ack === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Classic Wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 64);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        check(32'(n < 64), 1, "bus answer");
    endtask

    // One device transfer through the host engine; busy is polled
    task automatic dev(input logic w, input logic [7:0] ofs, input logic [31:0] d,
                       output logic [31:0] r);
        logic [31:0] s;
        int n;
        n = 0;
        wb(1'b1, HOFS_WDATA, d, s);
        wb(1'b1, HOFS_CTRL, {16'h0000, ofs, 6'h00, w, 1'b1}, s);
        do begin
            wb(1'b0, HOFS_STATUS, 32'h0000_0000, s);
            n++;
        end while (s[HSTAT_BUSY] !== 1'b0 && n < 64);
        check(32'(n < 64), 1, "busy cleared");
        wb(1'b0, HOFS_RDATA, 32'h0000_0000, r);
    endtask

    task automatic t_reset;
        dev(1'b0, OFS_DEVICE_COMMAND, 32'h0000_0000, q);
        check(q, DEVICE_COMMAND_RESET, "command reset");
        check({hold_o, angle_o, store_o, load_o}, 0, "outputs at reset");
    endtask

    // Offsets outside the map are refused by the host with no link traffic
    task automatic t_refuse;
        logic [7:0] bad [3] = '{8'hE8, 8'hED, 8'hFA};
        int         br;
        br = n_req;
        wb(1'b0, 5'h14, 32'h0000_0000, q);
        foreach (bad[i]) begin
            dev(1'b1, bad[i], 32'hFFFF_FFFF, q);
            wb(1'b0, HOFS_STATUS, 32'h0000_0000, q);
            check(q[HSTAT_REFUSED], 1, "refused flag");
        end
        check(n_req - br, 0, "refused link traffic");
    endtask

    // Store then load: request stands until completion, then bit reads zero
    task automatic t_copy;
        for (int b = 31; b >= 30; b--) begin
            dev(1'b1, OFS_DEVICE_COMMAND, 32'h1 << b, q);
            check(b == 31 ? store_o : load_o, 1, "copy started");
            dev(1'b0, OFS_DEVICE_COMMAND, 32'h0000_0000, q);
            check(q[b], 1, "copy bit pending");
            @(posedge clk_i) done_nvm <= 1'b1;
            @(posedge clk_i) done_nvm <= 1'b0;
            dev(1'b0, OFS_DEVICE_COMMAND, 32'h0000_0000, q);
            check({store_o, load_o, q[31:30]}, 0, "copy bit cleared");
        end
    endtask

    task automatic t_pulses;
        int bf, br;
        bf = n_flt;
        br = n_rty;
        dev(1'b1, OFS_DEVICE_COMMAND, 32'h3000_0000, q);
        check(n_flt - bf, 1, "fault clear pulse");
        check(n_rty - br, 1, "retry clear pulse");
    endtask

    task automatic t_selftest;
        int bs;
        bs = n_st;
        dev(1'b1, OFS_DEVICE_COMMAND, 32'h0000_0200, q);
        check(n_st - bs, 1, "self test start");
        dev(1'b0, OFS_DEVICE_COMMAND, 32'h0000_0000, q);
        check(q[BIT_SELFTEST], 1, "self test pending");
        check(q[SELFTEST_KEY_MSB:SELFTEST_KEY_LSB], SELFTEST_KEY, "self test key");
        @(posedge clk_i) done_st <= 1'b1;
        @(posedge clk_i) done_st <= 1'b0;
        dev(1'b0, OFS_DEVICE_COMMAND, 32'h0000_0000, q);
        check(q[BIT_SELFTEST], 0, "self test done");
    endtask

    // Angle wraps modulo a full turn, including the 9-bit limit
    task automatic t_align;
        logic [8:0] ang [5] = '{9'd225, 9'd359, 9'd360, 9'd395, 9'd511};
        logic [8:0] exp [5] = '{9'd225, 9'd359, 9'd0, 9'd35, 9'd151};
        method <= STARTUP_ALIGN;
        dev(1'b1, OFS_DEBUG_CONTROL_ONE, 32'h0000_4000, q);
        foreach (ang[i]) begin
            dev(1'b1, OFS_DEVICE_COMMAND, {12'h000, ang[i], 11'h000}, q);
            check(angle_o, exp[i], "align angle");
        end
        check(hold_o, 1, "align hold");
        @(posedge clk_i) method <= 3'h0;
        repeat (3) @(posedge clk_i);
        check(hold_o, 0, "hold other method");
        @(posedge clk_i) method <= STARTUP_DOUBLE_ALIGN;
        repeat (3) @(posedge clk_i);
        check(hold_o, 1, "hold double align");
        dev(1'b1, OFS_DEBUG_CONTROL_ONE, 32'h0000_0000, q);
        check({hold_o, angle_o}, 0, "align disabled");
    endtask

    // Host tickles every 50 cycles; device clears the bit itself
    task automatic t_wdt;
        int bt;
        bt = n_tkl;
        wb(1'b1, HOFS_WDT_INTV, 32'h0000_0032, q);
        repeat (130) @(posedge clk_i);
        wb(1'b1, HOFS_WDT_INTV, 32'h0000_0000, q);
        check(32'((n_tkl - bt) inside {[2:3]}), 1, "tickle count");
        // Software traffic beside frequent tickles, phase swept by idle gaps
        bt = n_tkl;
        wb(1'b1, HOFS_WDT_INTV, 32'h0000_0007, q);
        for (int i = 0; i < 14; i++) begin
            repeat (i % 7) @(posedge clk_i);
            dev(1'b1, OFS_DEBUG_CONTROL_TWO, 32'(i), q);
            dev(1'b0, OFS_DEBUG_CONTROL_TWO, 32'h0000_0000, q);
            check(q, 32'(i), "write beside tickles");
        end
        wb(1'b1, HOFS_WDT_INTV, 32'h0000_0000, q);
        check(32'(n_tkl > bt), 1, "tickles beside traffic");
        dev(1'b0, OFS_DEVICE_COMMAND, 32'h0000_0000, q);
        check(q[BIT_WDT_TICKLE], 0, "tickle cleared");
    endtask

    // Main sequence
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, done_nvm, done_st} = 5'h00;
        adr = 5'h00;
        dat = 32'h0000_0000;
        method = 3'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_refuse();
        t_copy();
        t_pulses();
        t_selftest();
        t_align();
        t_wdt();
        tally_and_finish();
    end

    // Hang guard, well beyond the expected run of about a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
endmodule // testbench
